// file: design/mpc_top.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - Debug mode outputs C, D, Z events
// RULE_02 - Speed mode debug outputs C and speed
// RULE_03 - W waveform reaches pin only when enabled
// RULE_04 - V waveform reaches pin only when enabled
// RULE_05 - U waveform reaches pin only when enabled
// RULE_06 - Sensorless zero-delay minimum off-time (code+1)*2.5us; the code applies none while on-time sampling is set
// RULE_07 - Nonzero delay code delays sample code*2.5us
// RULE_08 - Zero delay code samples in off-time
// RULE_09 - Slipped sample discarded, pending flag set
// RULE_10 - Mask bit gates crossing-sample slip interrupt
// RULE_11 - Slip interrupt only with nonzero delay
// RULE_12 - Software masks slip during changes
// RULE_13 - Divider field gives 1, 2, 4, 4
// RULE_14 - Software aims for 4 MHz peripheral
// RULE_15 - Durations counted in peripheral ticks
// RULE_16 - Reset values 02h and 00h
// RULE_17 - Interrupt when pending and mask; write 0 clears
module mpc_top
  import mpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire mpc_phase_t phaseWave,
  input wire mpc_evt_t events,
  input wire logic switchedMode,
  input wire logic pwmOnTime,
  input wire logic crossingSampleReq,
  output mpc_phase_t phaseWavePin,
  output logic debugCommutationPin,
  output logic debugCrossingPin,
  output logic crossingSampleTake,
  output logic minOffHold,
  output logic periphTick,
  output logic irq
);

  function automatic logic [7:0] stepsToTicks(input logic [3:0] code);
    stepsToTicks = 8'(int'(code) * STEP_TICKS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] waveCtrl_q;
  logic [7:0] sampleCfg_q;
  logic [7:0] sampleCfg_d;
  logic [7:0] modeCtrl_q;
  logic [7:0] irqStatus_q;
  logic [7:0] irqStatus_d;
  logic [7:0] irqMask_q;
  logic [7:0] rdata_q;
  logic [1:0] divCnt_q;
  logic [7:0] delayCnt_q;
  logic [7:0] delayCnt_d;
  logic delayBusy_q;
  logic delayBusy_d;
  logic [7:0] offCnt_q;
  logic [7:0] offCnt_d;
  logic pwmOnPrev_q;
  mpc_phase_t phasePin_q;
  logic dbgComm_q;
  logic dbgCross_q;
  logic sampleTake_q;
  logic sampleTake_d;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire wrWave = regWrite && (regAddr == ADDR_WAVE_CTRL);
  wire wrSample = regWrite && (regAddr == ADDR_SAMPLE_CFG);
  wire wrStatus = regWrite && (regAddr == ADDR_IRQ_STATUS);
  wire wrMask = regWrite && (regAddr == ADDR_IRQ_MASK);
  wire wrMode = regWrite && (regAddr == ADDR_MODE_CTRL);

  wire [3:0] offTimeSel = waveCtrl_q[LSB_OFF_TIME +: 4];
  wire [3:0] sampleDelay = sampleCfg_q[LSB_SAMPLE_DELAY +: 4];
  wire delayNonZero = (sampleDelay != 4'h0);
  wire debugEn = waveCtrl_q[BIT_DEBUG_EN];
  wire sensorMode = modeCtrl_q[BIT_SENSOR_MODE];
  wire onTimeSampling = modeCtrl_q[BIT_ON_TIME_SAMPLING];
  wire speedMeas = modeCtrl_q[BIT_SPEED_MEAS];
  wire [1:0] divSel = {sampleCfg_q[BIT_CLK_DIV_HI], sampleCfg_q[BIT_CLK_DIV_LO]};

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral clock enable: 00 /1, 01 /2, 1x /4
  wire tickNow = (divSel == 2'h0) ||
                 ((divSel == 2'h1) && divCnt_q[0]) ||
                 (divSel[1] && (divCnt_q == 2'h3)); // [RULE_13]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_q <= 2'h0;
    end else begin
      divCnt_q <= divCnt_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample delay: the delay is counted in peripheral ticks, so all
  // durations scale with the divider setting
  wire sampleStart = crossingSampleReq && delayNonZero && !delayBusy_q;
  wire delayDone = delayBusy_q && tickNow && (delayCnt_q <= 8'h01);
  wire slipEvent = delayDone && !pwmOnTime; // [RULE_09]

  always_comb begin
    delayCnt_d = delayCnt_q;
    delayBusy_d = delayBusy_q;
    sampleTake_d = 1'b0;
    if (sampleStart) begin
      delayCnt_d = stepsToTicks(sampleDelay); // [RULE_07] [RULE_15]
      delayBusy_d = 1'b1;
    end else if (delayDone) begin
      delayBusy_d = 1'b0;
      sampleTake_d = pwmOnTime; // [RULE_07] [RULE_09]
    end else if (delayBusy_q && tickNow) begin
      delayCnt_d = delayCnt_q - 8'h01;
    end
    // Zero delay: take the request at once, inside the off-time
    if (crossingSampleReq && !delayNonZero && !pwmOnTime) begin
      sampleTake_d = 1'b1; // [RULE_08]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Minimum off-time, sensorless with zero delay and on-time sampling off only
  wire offTimeActive = !sensorMode && !onTimeSampling && !delayNonZero; // [RULE_06]
  wire onFall = pwmOnPrev_q && !pwmOnTime;
  wire offDone = (offCnt_q == 8'h01) && tickNow;

  always_comb begin
    offCnt_d = offCnt_q;
    if (!offTimeActive) begin
      offCnt_d = 8'h00; // [RULE_06]
    end else if (onFall) begin
      offCnt_d = stepsToTicks(offTimeSel) + 8'(STEP_TICKS); // [RULE_06] [RULE_15]
    end else if ((offCnt_q != 8'h00) && tickNow) begin
      offCnt_d = offCnt_q - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; hardware set wins over a software clear
  always_comb begin
    sampleCfg_d = sampleCfg_q;
    if (wrSample) begin
      sampleCfg_d = {regWdata[7:4], sampleCfg_q[BIT_SLIP_PENDING] & regWdata[BIT_SLIP_PENDING],
                     regWdata[2:0]}; // [RULE_17]
    end
    if (slipEvent) begin
      sampleCfg_d[BIT_SLIP_PENDING] = 1'b1; // [RULE_09]
    end
  end

  always_comb begin
    irqStatus_d = irqStatus_q;
    if (wrStatus) begin
      irqStatus_d = irqStatus_q & ~regWdata;
    end
    if (slipEvent) begin
      irqStatus_d[BIT_STS_SLIP] = 1'b1;
    end
    if (sampleTake_d) begin
      irqStatus_d[BIT_STS_SAMPLE] = 1'b1;
    end
    if (offDone) begin
      irqStatus_d[BIT_STS_OFF_DONE] = 1'b1;
    end
    irqStatus_d[7:3] = 5'h00;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waveCtrl_q <= RST_WAVE_CTRL; // [RULE_16]
      sampleCfg_q <= RST_SAMPLE_CFG; // [RULE_16]
      modeCtrl_q <= RST_MODE_CTRL;
      irqMask_q <= RST_IRQ_MASK;
      irqStatus_q <= 8'h00;
    end else begin
      if (wrWave) begin
        waveCtrl_q <= regWdata;
      end
      if (wrMode) begin
        modeCtrl_q <= {4'h0, regWdata[3:0]};
      end
      if (wrMask) begin
        irqMask_q <= {5'h00, regWdata[2:0]};
      end
      sampleCfg_q <= sampleCfg_d;
      irqStatus_q <= irqStatus_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      delayCnt_q <= 8'h00;
      delayBusy_q <= 1'b0;
      offCnt_q <= 8'h00;
      pwmOnPrev_q <= 1'b0;
      sampleTake_q <= 1'b0;
    end else begin
      delayCnt_q <= delayCnt_d;
      delayBusy_q <= delayBusy_d;
      offCnt_q <= offCnt_d;
      pwmOnPrev_q <= pwmOnTime;
      sampleTake_q <= sampleTake_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase and debug pins, registered so the power stage sees clean edges
  wire dbgCommNext = debugEn && (speedMeas ? events.commutation :
                     (switchedMode && (events.commutation || events.demag))); // [RULE_01] [RULE_02]
  wire dbgCrossNext = debugEn && (speedMeas ? events.speedUpdate :
                      (switchedMode && events.crossing)); // [RULE_01] [RULE_02]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phasePin_q <= '0;
      dbgComm_q <= 1'b0;
      dbgCross_q <= 1'b0;
    end else begin
      phasePin_q.w <= phaseWave.w && waveCtrl_q[BIT_W_EN]; // [RULE_03]
      phasePin_q.v <= phaseWave.v && waveCtrl_q[BIT_V_EN]; // [RULE_04]
      phasePin_q.u <= phaseWave.u && waveCtrl_q[BIT_U_EN]; // [RULE_05]
      dbgComm_q <= dbgCommNext;
      dbgCross_q <= dbgCrossNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe; unmapped reads zero
  wire [7:0] rdMux = (regAddr == ADDR_WAVE_CTRL) ? waveCtrl_q :
                     (regAddr == ADDR_SAMPLE_CFG) ? sampleCfg_q :
                     (regAddr == ADDR_IRQ_STATUS) ? irqStatus_q :
                     (regAddr == ADDR_IRQ_MASK) ? irqMask_q :
                     (regAddr == ADDR_MODE_CTRL) ? modeCtrl_q : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (regRead) begin
      rdata_q <= rdMux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt; slip source only counts with a delay programmed, since
  // with zero delay no sample is aimed at the on-time
  wire slipIrq = sampleCfg_q[BIT_SLIP_PENDING] && sampleCfg_q[BIT_SLIP_IRQ_EN] &&
                 delayNonZero; // [RULE_10] [RULE_11] [RULE_17]

  assign irq = slipIrq || ((irqStatus_q & irqMask_q) != 8'h00);
  assign regRdata = rdata_q;
  assign phaseWavePin = phasePin_q;
  assign debugCommutationPin = dbgComm_q;
  assign debugCrossingPin = dbgCross_q;
  assign crossingSampleTake = sampleTake_q;
  // No hold at all outside sensorless zero-delay operation
  assign minOffHold = (offCnt_q != 8'h00) || (onFall && offTimeActive); // [RULE_06]
  assign periphTick = tickNow;

endmodule

// file: design/mpc_pkg.sv
package mpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte offsets on the plain register port)
  localparam logic [7:0] ADDR_WAVE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SAMPLE_CFG = 8'h01;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h02;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h03;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h04;

  // Reset values
  localparam logic [7:0] RST_WAVE_CTRL = 8'h00;
  localparam logic [7:0] RST_SAMPLE_CFG = 8'h02;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;

  // Field positions, waveform_output_debug_control
  localparam int BIT_DEBUG_EN = 7;
  localparam int BIT_W_EN = 6;
  localparam int BIT_V_EN = 5;
  localparam int BIT_U_EN = 4;
  localparam int LSB_OFF_TIME = 0;

  // Field positions, sampling_clock_config
  localparam int LSB_SAMPLE_DELAY = 4;
  localparam int BIT_SLIP_PENDING = 3;
  localparam int BIT_SLIP_IRQ_EN = 2;
  localparam int BIT_CLK_DIV_HI = 1;
  localparam int BIT_CLK_DIV_LO = 0;

  // Field positions, mode control
  localparam int BIT_SENSOR_MODE = 0;
  localparam int BIT_ON_TIME_SAMPLING = 1;
  localparam int BIT_SW_CROSSING = 2;
  localparam int BIT_SPEED_MEAS = 3;

  // Status and mask bits
  localparam int BIT_STS_SLIP = 0;
  localparam int BIT_STS_SAMPLE = 1;
  localparam int BIT_STS_OFF_DONE = 2;

  // Timing: one step is 2.5 us at a 4 MHz peripheral clock
  localparam int STEP_PS = 2500000;
  localparam int PERIPH_REF_KHZ = 4000;
  localparam int STEP_TICKS = STEP_PS / 1000 * PERIPH_REF_KHZ / 1000000;

  typedef struct packed {
    logic commutation;
    logic demag;
    logic crossing;
    logic speedUpdate;
  } mpc_evt_t;

  typedef struct packed {
    logic u;
    logic v;
    logic w;
  } mpc_phase_t;

endpackage

// file: tb/mpc_assertions.sv
`timescale 1ns/1ps
module mpc_assertions
  import mpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire mpc_phase_t phaseWave,
  input wire mpc_evt_t events,
  input wire logic switchedMode,
  input wire logic pwmOnTime,
  input wire logic crossingSampleReq,
  input wire mpc_phase_t phaseWavePin,
  input wire logic debugCrossingPin,
  input wire logic crossingSampleTake,
  input wire logic periphTick,
  input wire logic irq
);
  // Shadows of software-written fields; the hardware-set pending bit is not tracked
  logic [7:0] ctl_q, cfg_q, msk_q, mod_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= RST_WAVE_CTRL;
      cfg_q <= RST_SAMPLE_CFG;
      msk_q <= RST_IRQ_MASK;
      mod_q <= RST_MODE_CTRL;
    end else if (regWrite) begin
      if (regAddr == ADDR_WAVE_CTRL) ctl_q <= regWdata;
      if (regAddr == ADDR_SAMPLE_CFG) cfg_q <= regWdata;
      if (regAddr == ADDR_IRQ_MASK) msk_q <= regWdata;
      if (regAddr == ADDR_MODE_CTRL) mod_q <= regWdata;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  pin_w_gate_a: assert property (phaseWavePin.w == $past(phaseWave.w & ctl_q[BIT_W_EN]))
    else $error("w pin gate wrong");
  pin_v_gate_a: assert property (phaseWavePin.v == $past(phaseWave.v & ctl_q[BIT_V_EN]))
    else $error("v pin gate wrong");
  pin_u_gate_a: assert property (phaseWavePin.u == $past(phaseWave.u & ctl_q[BIT_U_EN]))
    else $error("u pin gate wrong");
  dbg_cross_a: assert property (ctl_q[BIT_DEBUG_EN] && switchedMode
    && !mod_q[BIT_SPEED_MEAS] && events.crossing |=> debugCrossingPin) else $error("no crossing");
  dbg_speed_a: assert property (ctl_q[BIT_DEBUG_EN] && mod_q[BIT_SPEED_MEAS]
    && events.speedUpdate |=> debugCrossingPin) else $error("no speed update");
  div_one_a: assert property (cfg_q[1:0] == 2'b00 |-> periphTick)
    else $error("tick missing at divide by one");
  div_four_a: assert property (periphTick && cfg_q[1] |=> (!periphTick || !cfg_q[1])[*3])
    else $error("tick too early at divide by four");
  irq_no_delay_a: assert property (cfg_q[7:4] == 4'h0 && msk_q[2:0] == 3'b000 |-> !irq)
    else $error("irq without delay");
  off_sample_a: assert property (cfg_q[7:4] == 4'h0 && crossingSampleReq && !pwmOnTime
    |=> crossingSampleTake) else $error("off-time sample missing");
  cover property (irq);
  cover property (crossingSampleTake);
  cover property ($rose(debugCrossingPin));
endmodule
bind mpc_top mpc_assertions chk (.clk, .reset_n, .regAddr, .regWdata, .regWrite, .phaseWave,
  .events, .switchedMode, .pwmOnTime, .crossingSampleReq, .phaseWavePin, .debugCrossingPin,
  .crossingSampleTake, .periphTick, .irq);

// file: tb/mpc_inverter_model.sv
`timescale 1ns/1ps
module mpc_inverter_model
  import mpc_pkg::*;
(
  input wire mpc_phase_t gateDrive,
  output logic onSense
);
  // Any conducting high side reads back as on-time; a withheld wave leaves its leg off
  assign onSense = |gateDrive;
endmodule

// file: tb/mpc_top_tb.sv
`timescale 1ns/1ps
module mpc_top_tb
  import mpc_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  mpc_phase_t phaseWave = '0;
  mpc_evt_t events = '0;
  logic switchedMode = 1'b0;
  logic crossingSampleReq = 1'b0;
  logic pwmOnTime, debugCommutationPin, debugCrossingPin, crossingSampleTake;
  logic minOffHold, periphTick, irq;
  mpc_phase_t phaseWavePin;
  int fails = 0;
  int checkCount = 0;
  always #2.5 clk = ~clk;
  mpc_top dut (.clk, .reset_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .phaseWave,
    .events, .switchedMode, .pwmOnTime, .crossingSampleReq, .phaseWavePin, .debugCommutationPin,
    .debugCrossingPin, .crossingSampleTake, .minOffHold, .periphTick, .irq);
  mpc_inverter_model inv (.gateDrive(phaseWavePin), .onSense(pwmOnTime));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  task automatic evt(input logic [3:0] e, input logic sw, input logic [1:0] exp);
    @(posedge clk);
    events <= mpc_evt_t'(e);
    switchedMode <= sw;
    @(posedge clk);
    events <= '0;
    #1 chk({6'h00, debugCommutationPin, debugCrossingPin}, {6'h00, exp});
  endtask
  task automatic t_pins();
    phaseWave <= 3'b111;
    for (int e = 0; e < 8; e++) begin
      wr(ADDR_WAVE_CTRL, {1'b0, e[2:0], 4'h0});
      @(posedge clk);
      #1 chk({5'h00, phaseWavePin}, {5'h00, e[0], e[1], e[2]});
    end
  endtask
  task automatic t_debug();
    wr(ADDR_WAVE_CTRL, 8'h80);
    evt(4'h2, 1'b1, 2'b01);
    evt(4'h4, 1'b1, 2'b10);
    evt(4'h8, 1'b1, 2'b10);
    evt(4'h2, 1'b0, 2'b00);
    wr(ADDR_MODE_CTRL, 8'h08);
    evt(4'h1, 1'b0, 2'b01);
    evt(4'h8, 1'b0, 2'b10);
    evt(4'h2, 1'b1, 2'b00);
    wr(ADDR_WAVE_CTRL, 8'h00);
    evt(4'h2, 1'b1, 2'b00);
  endtask
  task automatic t_div();
    int n;
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_SAMPLE_CFG, 8'(d));
      n = 0;
      repeat (16) begin
        @(posedge clk);
        #1 n += periphTick;
      end
      chk(8'(n), (d == 0) ? 8'h10 : (d == 1) ? 8'h08 : 8'h04);
    end
  endtask
  task automatic t_minoff(input logic [7:0] mode, input logic [7:0] exp);
    int n;
    wr(ADDR_MODE_CTRL, mode);
    phaseWave <= 3'b100;
    repeat (3) @(posedge clk);
    phaseWave <= '0;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      #1 n += minOffHold;
    end
    chk(8'(n), exp);
  endtask
  task automatic t_req(input logic on, input int drop, output int k);
    @(posedge clk);
    phaseWave <= {on, 2'b00};
    crossingSampleReq <= 1'b1;
    @(posedge clk);
    crossingSampleReq <= 1'b0;
    k = 0;
    repeat (20) begin
      #1;
      if (crossingSampleTake === 1'b1) break;
      @(posedge clk);
      if (k == drop) phaseWave <= '0;
      k++;
    end
  endtask
  task automatic t_sample();
    int k;
    wr(ADDR_SAMPLE_CFG, 8'h14);
    t_req(1'b1, 99, k);
    chk(8'(k), 8'h0A);
    chk({7'h00, irq}, 8'h00);
    t_req(1'b1, 3, k);
    chk(8'(k), 8'h14);
    chk({7'h00, irq}, 8'h01);
    rd(ADDR_SAMPLE_CFG, 8'h1C);
    wr(ADDR_SAMPLE_CFG, 8'h18);
    #1 chk({7'h00, irq}, 8'h00);
    rd(ADDR_SAMPLE_CFG, 8'h18);
    wr(ADDR_SAMPLE_CFG, 8'h14);
    rd(ADDR_SAMPLE_CFG, 8'h14);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_SAMPLE_CFG, 8'h00); // Mask dropped with the delay change
    t_req(1'b0, 99, k);
    chk(8'(k), 8'h00);
  endtask
  task automatic endOfTest();
    $display("comparisons %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_SAMPLE_CFG, RST_SAMPLE_CFG);
    rd(ADDR_WAVE_CTRL, 8'h00);
    rd(8'h07, 8'h00);
    t_pins();
    t_debug();
    t_div();
    wr(ADDR_SAMPLE_CFG, 8'h00); // Undivided, one tick per clock
    wr(ADDR_WAVE_CTRL, 8'h12);
    // Thirty ticks of hold plus the cycle in which the on-time falls
    t_minoff(8'h00, 8'h1F);
    t_minoff(8'h01, 8'h00);
    t_minoff(8'h02, 8'h00);
    t_sample();
    endOfTest();
  end
endmodule
